// file: inc/css_defines.svh
// Constants for the configuration startup sequencer.
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH
`define CSS_PHASE_W        3
`define CSS_LAST_PHASE     3'h7
`define CSS_DONE_DEF       4'h4
`define CSS_IO_REL_DEF     4'h5
`define CSS_WE_DEF         4'h6
`define CSS_IMP_AUTO_PHASE 4'h2
`define CSS_SEL_DONE       4'h8
`define CSS_SEL_KEEP       4'h9
`define CSS_SEL_NO_WAIT    4'hA
`define CSS_SEL_AUTO       4'hB
`define CSS_LOCK_NONE      2'h0
`define CSS_LOCK_ONE       2'h1
`define CSS_LOCK_TWO       2'h2
`endif

// file: inc/css_pkg.sv
// Types shared by the configuration startup sequencer files.
package css_pkg;
   // Startup clock sources.
   typedef enum logic [1:0] {
      CSS_CLK_CONFIG,
      CSS_CLK_USER,
      CSS_CLK_SCAN
   } css_clk_sel_t;
   // Internal configuration port choices.
   typedef enum logic [1:0] {
      CSS_PORT_AUTO,
      CSS_PORT_TOP,
      CSS_PORT_BOTTOM
   } css_port_sel_t;
   // Phase selection fields; codes 0..7 name a phase, codes with bit three set are special.
   typedef struct packed {
      logic [3:0] done_sel;
      logic [3:0] io_rel_sel;
      logic [3:0] we_sel;
      logic [3:0] lock_sel;
      logic [3:0] imp_sel;
   } css_phase_cfg_t;
   // Global control outputs.
   typedef struct packed {
      logic done;
      logic tristate;
      logic write_en;
      logic bram_en;
      logic out_hold;
      logic set_reset;
   } css_glob_t;
endpackage

// file: core/css_phase_match.sv
// Phase selection matcher for the startup sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.svh"
module css_phase_match (
   input  wire logic [3:0] sel,        // Selection code.
   input  wire logic [2:0] phase,      // Current phase.
   input  wire logic       done_seen,  // Done state already entered.
   output logic            hit         // Selected phase reached.
);
   // A numbered phase fires once reached; done follows the done state; keep never fires.
   always_comb begin
      if (sel == `CSS_SEL_DONE) begin
         hit = done_seen;
      end else if (sel[3]) begin
         hit = 1'b0;
      end else begin
         hit = (phase >= sel[2:0]);
      end
   end
endmodule
`default_nettype wire

// file: core/css_sequencer.sv
// Configuration startup sequencer: phase stepping and global control outputs.
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.svh"
//
// Operation
// - done output fires in selected phase, default 4.
// - tristate release in selected phase, default 5.
// - global write enable in selected phase, default 6.
// - block RAM access blocked before write enable.
// - hold in lock phase until managers lock.
// - no_wait_a ignores clock manager lock.
// - stall in impedance phase until matched.
// - reaching wait phase does not start matching.
// - automatic impedance phase resolves to two or none.
// - done pipeline waits pin high plus edge.
// - startup clock selectable config, user or scan.
// - live reconfig suppresses hold and set reset.
// - lock levels refuse readback and reconfiguration.
// - frame check mismatch pulls init low and raises error.
// - internal port routed to top or bottom.
// - monitor safe mode during reconfig when enabled.
module css_sequencer #(
   parameter logic [3:0] DONE_DEF = `CSS_DONE_DEF  // Default done phase.
) (
   input  wire logic                  mclk,               // System clock.
   input  wire logic                  nrst,               // Synchronous reset, active low.
   input  wire logic                  start,              // Configuration loaded, begin startup.
   input  wire css_pkg::css_phase_cfg_t phase_cfg,        // Phase selections.
   input  wire css_pkg::css_clk_sel_t sequencer_clock_sel,// Startup clock source.
   input  wire logic                  config_clock,       // Configuration clock level.
   input  wire logic                  user_clock_source,  // User clock level.
   input  wire logic                  scan_clock_source,  // Scan clock level.
   input  wire logic                  clk_mgr_locked,     // All clock managers locked.
   input  wire logic                  impedance_match,    // Impedance matching complete.
   input  wire logic                  design_uses_match,  // Design has matched I/O.
   input  wire logic                  done_pipeline,      // Wait for done pin first.
   input  wire logic                  config_done_pin,    // Level seen on the done pin.
   input  wire logic                  live_reconfig_hold, // Suppress hold and set reset.
   input  wire logic                  in_configuration,   // Configuration under way.
   input  wire logic [1:0]            readback_lock_level,// Security level.
   input  wire logic                  readback_req,       // Readback requested.
   input  wire logic                  reconfig_req,       // Reconfiguration requested.
   input  wire logic                  frame_check_insert, // Frame check enable.
   input  wire logic                  frame_word_valid,   // Check word strobe.
   input  wire logic [31:0]           frame_check_calc,   // Computed check value.
   input  wire logic [31:0]           frame_check_rx,     // Check value from stream.
   input  wire logic                  frame_clear,        // Clears frame error.
   input  wire css_pkg::css_port_sel_t internal_port_sel, // Port selection.
   input  wire logic                  port_access,        // Internal access request.
   input  wire logic                  monitor_safe_reconfig, // Monitor safe mode enable.
   input  wire logic                  partial_reconfig,   // Partial reconfig under way.
   input  wire logic                  bram_req,           // Block RAM access request.
   output logic [2:0]                 phase_q,            // Current startup phase.
   output css_pkg::css_glob_t         glob_q,             // Global controls.
   output logic                       config_done,        // Done output.
   output logic                       init_status_n,      // Init status, low on error.
   output logic                       frame_error_flag,   // Frame check error.
   output logic                       readback_grant,     // Readback permitted.
   output logic                       reconfig_grant,     // Reconfiguration permitted.
   output logic                       port_top_sel,       // Top internal port active.
   output logic                       port_bottom_sel,    // Bottom internal port active.
   output logic                       monitor_safe_mode,  // Analog monitor safe mode.
   output logic                       bram_grant          // Block RAM access granted.
);
   // ************************************************************
   // Startup clock selection and edge detection
   // ************************************************************
   logic sel_clk;      // Selected startup clock level.
   logic sel_clk_q;    // Previous level for edge detection.
   logic clk_rise;     // Rising edge of selected clock.
   logic running_q;    // Sequence in progress.
   logic done_seen_q;  // Done state entered.
   logic pipe_arm_q;   // Done pin observed high, awaiting edge.

   // The clock inputs are sampled levels, so only rising edges are stepped on.
   always_comb begin
      case (sequencer_clock_sel)
         css_pkg::CSS_CLK_USER: sel_clk = user_clock_source;
         css_pkg::CSS_CLK_SCAN: sel_clk = scan_clock_source;
         default:               sel_clk = config_clock;
      endcase
   end

   // Previous clock level register.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sel_clk_q <= 1'b0;
      end else begin
         sel_clk_q <= sel_clk;
      end
   end

   assign clk_rise = sel_clk & ~sel_clk_q;

   // ************************************************************
   // Wait conditions
   // ************************************************************
   logic [3:0] imp_eff;   // Resolved impedance wait selection.
   logic       lock_hold; // Lock wait holding the phase.
   logic       imp_hold;  // Impedance wait holding the phase.
   logic       advance;   // Phase steps this cycle.

   // Automatic impedance choice depends on whether matched I/O is used.
   always_comb begin
      if (phase_cfg.imp_sel == `CSS_SEL_AUTO) begin
         imp_eff = design_uses_match ? `CSS_IMP_AUTO_PHASE : `CSS_SEL_NO_WAIT;
      end else begin
         imp_eff = phase_cfg.imp_sel;
      end
   end

   // Codes with bit three set mean no wait; lock status is then ignored.
   assign lock_hold = !phase_cfg.lock_sel[3] && (phase_q == phase_cfg.lock_sel[2:0])
                      && !clk_mgr_locked;
   // The matching itself runs elsewhere; this only holds until it reports done.
   assign imp_hold  = !imp_eff[3] && (phase_q == imp_eff[2:0]) && !impedance_match;
   assign advance   = running_q && clk_rise && !lock_hold && !imp_hold
                      && (phase_q != `CSS_LAST_PHASE);

   // ************************************************************
   // Phase counter
   // ************************************************************
   // One phase per selected clock edge; a stalled edge is simply dropped.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         phase_q <= 3'h0;
      end else if (!running_q) begin
         phase_q <= 3'h0;
      end else if (advance) begin
         phase_q <= phase_q + 3'h1;
      end
   end

   // Run flag rises on start and stays until reset.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         running_q <= 1'b0;
      end else if (start) begin
         running_q <= 1'b1;
      end
   end

   // ************************************************************
   // Phase matches
   // ************************************************************
   logic done_hit; // Done phase reached.
   logic io_hit;   // Tristate release phase reached.
   logic we_hit;   // Write enable phase reached.

   css_phase_match u_done (
      .sel       (phase_cfg.done_sel),
      .phase     (phase_q),
      .done_seen (1'b0),
      .hit       (done_hit)
   );
   css_phase_match u_io (
      .sel       (phase_cfg.io_rel_sel),
      .phase     (phase_q),
      .done_seen (done_seen_q),
      .hit       (io_hit)
   );
   css_phase_match u_we (
      .sel       (phase_cfg.we_sel),
      .phase     (phase_q),
      .done_seen (done_seen_q),
      .hit       (we_hit)
   );

   // ************************************************************
   // Done state with optional pipeline
   // ************************************************************
   // With the pipeline, the done pin must read high and one more edge must pass.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pipe_arm_q  <= 1'b0;
         done_seen_q <= 1'b0;
      end else if (running_q && done_hit && !done_seen_q) begin
         if (!done_pipeline) begin
            done_seen_q <= 1'b1;
         end else if (pipe_arm_q && clk_rise) begin
            done_seen_q <= 1'b1;
         end else if (config_done_pin) begin
            pipe_arm_q  <= 1'b1;
         end
      end
   end

   // Done output register; the master keeps clocking until this is high.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         config_done <= 1'b0;
      end else begin
         config_done <= done_seen_q;
      end
   end

   // ************************************************************
   // Global controls
   // ************************************************************
   // Tristate is held until release; write enable and block RAM follow one phase.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         glob_q <= '{done: 1'b0, tristate: 1'b1, write_en: 1'b0, bram_en: 1'b0,
                     out_hold: 1'b0, set_reset: 1'b0};
      end else begin
         glob_q.done      <= done_seen_q;
         glob_q.tristate  <= !(running_q && io_hit);
         glob_q.write_en  <= running_q && we_hit;
         glob_q.bram_en   <= running_q && we_hit;
         glob_q.out_hold  <= in_configuration && !live_reconfig_hold;
         glob_q.set_reset <= in_configuration && !live_reconfig_hold;
      end
   end

   // Block RAM requests are refused until write enable is on.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bram_grant <= 1'b0;
      end else begin
         bram_grant <= bram_req && running_q && we_hit;
      end
   end

   // ************************************************************
   // Security, port routing and monitor mode
   // ************************************************************
   // Level one blocks readback; level two blocks readback and reconfiguration.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         readback_grant <= 1'b0;
         reconfig_grant <= 1'b0;
      end else begin
         readback_grant <= readback_req && (readback_lock_level == `CSS_LOCK_NONE);
         reconfig_grant <= reconfig_req && (readback_lock_level != `CSS_LOCK_TWO);
      end
   end

   // Automatic selection settles on the top port.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         port_top_sel    <= 1'b0;
         port_bottom_sel <= 1'b0;
      end else begin
         port_top_sel    <= port_access && (internal_port_sel != css_pkg::CSS_PORT_BOTTOM);
         port_bottom_sel <= port_access && (internal_port_sel == css_pkg::CSS_PORT_BOTTOM);
      end
   end

   // Safe mode only while a partial reconfiguration runs with the option on.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         monitor_safe_mode <= 1'b0;
      end else begin
         monitor_safe_mode <= monitor_safe_reconfig && partial_reconfig;
      end
   end

   // ************************************************************
   // Frame check
   // ************************************************************
   logic mismatch; // Check word disagrees with computed value.

   assign mismatch = frame_check_insert && frame_word_valid
                     && (frame_check_calc != frame_check_rx);

   // Error is sticky; a new mismatch wins over a clear in the same cycle.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         frame_error_flag <= 1'b0;
         init_status_n    <= 1'b1;
      end else if (mismatch) begin
         frame_error_flag <= 1'b1;
         init_status_n    <= 1'b0;
      end else if (frame_clear) begin
         frame_error_flag <= 1'b0;
         init_status_n    <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: tb/css_sequencer_assertions.sv
// Port-level property checker for the configuration startup sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.svh"
module css_sequencer_assertions (
   input wire logic                    mclk,
   input wire logic                    nrst,
   input wire css_pkg::css_phase_cfg_t phase_cfg,
   input wire logic                    clk_mgr_locked,
   input wire logic                    impedance_match,
   input wire logic                    design_uses_match,
   input wire logic                    live_reconfig_hold,
   input wire logic                    in_configuration,
   input wire logic [1:0]              readback_lock_level,
   input wire logic                    readback_req,
   input wire logic                    reconfig_req,
   input wire logic                    frame_check_insert,
   input wire logic                    frame_word_valid,
   input wire logic [31:0]             frame_check_calc,
   input wire logic [31:0]             frame_check_rx,
   input wire logic                    bram_req,
   input wire logic [2:0]              phase_q,
   input wire css_pkg::css_glob_t      glob_q,
   input wire logic                    config_done,
   input wire logic                    init_status_n,
   input wire logic                    frame_error_flag,
   input wire logic                    readback_grant,
   input wire logic                    reconfig_grant,
   input wire logic                    bram_grant
);
   logic [3:0] imp_tgt;    // Impedance wait code after the automatic code is resolved.
   logic       lock_hold;  // Sitting in the lock phase with managers unlocked.
   logic       imp_hold;   // Sitting in the impedance phase before matching is done.
   assign imp_tgt = (phase_cfg.imp_sel != `CSS_SEL_AUTO) ? phase_cfg.imp_sel :
                    (design_uses_match ? `CSS_IMP_AUTO_PHASE : `CSS_SEL_NO_WAIT);
   assign lock_hold = phase_cfg.lock_sel < 4'h7 && {1'h0, phase_q} == phase_cfg.lock_sel &&
                      !clk_mgr_locked;
   assign imp_hold = imp_tgt < 4'h7 && {1'h0, phase_q} == imp_tgt && !impedance_match;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Three held cycles leave margin for the edge detector.
   a_phase_one_step: assert property (phase_q != $past(phase_q) |->
      $past(phase_q) != 3'h7 && phase_q == $past(phase_q) + 3'h1) else $error("phase jumped");
   a_lock_stall: assert property (lock_hold [*3] |=> $stable(phase_q))
      else $error("phase left lock wait");
   a_imp_stall: assert property (imp_hold [*3] |=> $stable(phase_q))
      else $error("phase left impedance wait");
   a_we_phase: assert property ($past(nrst) && $stable(phase_q) &&
      phase_cfg.we_sel inside {[4'h1:4'h6]} |->
      glob_q.write_en == (phase_q >= phase_cfg.we_sel[2:0])) else $error("write enable phase");
   a_io_release: assert property ($past(nrst) && $stable(phase_q) &&
      phase_cfg.io_rel_sel inside {[4'h1:4'h6]} |->
      glob_q.tristate == (phase_q < phase_cfg.io_rel_sel[2:0])) else $error("tristate phase");
   a_bram_gate: assert property (bram_grant |-> glob_q.write_en && $past(bram_req))
      else $error("block RAM granted early");
   a_readback_level: assert property ($past(nrst) |-> readback_grant ==
      ($past(readback_req) && $past(readback_lock_level) == 2'h0)) else $error("readback grant");
   a_reconfig_level: assert property (reconfig_grant |->
      $past(reconfig_req) && $past(readback_lock_level) != 2'h2) else $error("reconfig grant");
   a_frame_error: assert property (frame_check_insert && frame_word_valid &&
      frame_check_calc != frame_check_rx |=> frame_error_flag && !init_status_n)
      else $error("frame mismatch not flagged");
   a_live_quiet: assert property ((live_reconfig_hold && in_configuration) [*2] |->
      !glob_q.out_hold && !glob_q.set_reset) else $error("hold or set reset during live");
   a_done_phase: assert property (config_done && phase_cfg.done_sel < 4'h7 |->
      phase_q >= phase_cfg.done_sel[2:0]) else $error("done before its phase");
   c_phase_end: cover property (phase_q == 3'h7);
   c_lock_wait: cover property (lock_hold [*3]);
   c_frame_err: cover property ($rose(frame_error_flag));
   c_bram: cover property (bram_grant);
endmodule
bind css_sequencer css_sequencer_assertions chk_u (.mclk, .nrst, .phase_cfg, .clk_mgr_locked,
   .impedance_match, .design_uses_match, .live_reconfig_hold, .in_configuration,
   .readback_lock_level, .readback_req, .reconfig_req, .frame_check_insert, .frame_word_valid,
   .frame_check_calc, .frame_check_rx, .bram_req, .phase_q, .glob_q, .config_done,
   .init_status_n, .frame_error_flag, .readback_grant, .reconfig_grant, .bram_grant);
`default_nettype wire

// file: tb/css_cfg_master.sv
// Behavioural configuration master that drives the configuration clock.
`timescale 1ns/1ps
`default_nettype none
module css_cfg_master (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       go,           // Loads a new burst of rises.
   input  wire logic [3:0] count,        // Rises to give; 4'hF keeps going until done.
   input  wire logic       slow,         // Long half periods instead of the shortest.
   input  wire logic       config_done,
   output logic            config_clock
);
   logic [3:0] left_q;  // Rises still owed.
   logic [1:0] div_q;   // Cycles left in this half period.
   // The clock rests low between bursts, so no stray edge reaches the sequencer.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         left_q       <= 4'h0;
         div_q        <= 2'h0;
         config_clock <= 1'b0;
      end else if (go) begin
         left_q <= count;
      end else if (div_q != 2'h0) begin
         div_q <= div_q - 2'h1;
      end else if (config_clock) begin
         config_clock <= 1'b0;
         div_q        <= slow ? 2'h2 : 2'h0;
         if (left_q != 4'hF) begin
            left_q <= left_q - 4'h1;
         end
      end else if (left_q != 4'h0 && !(left_q == 4'hF && config_done)) begin
         config_clock <= 1'b1;
         div_q        <= slow ? 2'h2 : 2'h0;
      end
   end
endmodule
`default_nettype wire

// file: tb/css_sequencer_bench.sv
// Self-checking bench for the configuration startup sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.svh"
module css_sequencer_bench;
   logic                    mclk, nrst, start, config_clock, user_clock_source, scan_clock_source;
   logic                    clk_mgr_locked, impedance_match, design_uses_match, done_pipeline;
   logic                    config_done_pin, live_reconfig_hold, in_configuration, readback_req;
   logic                    reconfig_req, frame_check_insert, frame_word_valid, frame_clear;
   logic                    port_access, monitor_safe_reconfig, partial_reconfig, bram_req;
   logic [1:0]              readback_lock_level;
   logic [31:0]             frame_check_calc, frame_check_rx;
   css_pkg::css_phase_cfg_t phase_cfg, c;
   css_pkg::css_clk_sel_t   sequencer_clock_sel;
   css_pkg::css_port_sel_t  internal_port_sel;
   css_pkg::css_glob_t      glob_q;
   logic [2:0]              phase_q, p;
   logic                    config_done, init_status_n, frame_error_flag, readback_grant;
   logic                    reconfig_grant, port_top_sel, port_bottom_sel, monitor_safe_mode;
   logic                    bram_grant, cfg_go, cfg_slow;
   logic [3:0]              cfg_cnt;
   int                      err_total, num_checks, n;
   css_sequencer dut_u (.*);
   css_cfg_master cm_u (.mclk, .nrst, .go(cfg_go), .count(cfg_cnt), .slow(cfg_slow),
                        .config_done, .config_clock);
   // 40 MHz system clock.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic tick(int k);
      repeat (k) @(posedge mclk);
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Phase after k rises when the sequencer stalls at phase hold (7 means no stall).
   function automatic logic [2:0] exp_phase(int k, int hold);
      return 3'((k < hold) ? k : hold);
   endfunction
   // Fresh start, since the phase count only climbs until the next reset.
   task automatic restart(css_pkg::css_clk_sel_t s, css_pkg::css_phase_cfg_t cf);
      nrst <= 1'b0;
      start <= 1'b0;
      sequencer_clock_sel <= s;
      phase_cfg <= cf;
      tick(4);
      nrst <= 1'b1;
      tick(1);
      start <= 1'b1;
      tick(2);
   endtask
   // Rises of the selected source; with user or scan selected, the other bench clock toggles as a decoy.
   task automatic rises(int k);
      if (sequencer_clock_sel == css_pkg::CSS_CLK_CONFIG) begin
         cfg_cnt <= 4'(k);
         cfg_go <= 1'b1;
         cfg_slow <= 1'($urandom);
         tick(1);
         cfg_go <= 1'b0;
         tick(6 * k + 6);
      end else begin
         for (int i = 0; i < k; i++) begin
            user_clock_source <= (sequencer_clock_sel == css_pkg::CSS_CLK_USER);
            scan_clock_source <= (sequencer_clock_sel == css_pkg::CSS_CLK_SCAN);
            tick(2);
            user_clock_source <= (sequencer_clock_sel != css_pkg::CSS_CLK_USER);
            scan_clock_source <= (sequencer_clock_sel != css_pkg::CSS_CLK_SCAN);
            tick(2);
         end
         user_clock_source <= 1'b0;
         scan_clock_source <= 1'b0;
         tick(4);
      end
   endtask
   task automatic imp_case(logic [3:0] sel, logic uses, int k, int hold);
      c.imp_sel = sel;
      design_uses_match <= uses;
      impedance_match <= 1'b0;
      restart(css_pkg::css_clk_sel_t'(k % 3), c);
      rises(k);
      check("imp", phase_q, exp_phase(k, hold));
      impedance_match <= 1'b1;
      rises(2);
      check("imp", phase_q, exp_phase(exp_phase(k, hold) + 2, 7));
   endtask
   task automatic frame_op(logic en, logic mis, logic clr, logic exp);
      logic [31:0] r;
      r = $urandom;
      frame_check_insert <= en;
      frame_word_valid <= 1'b1;
      frame_check_calc <= r;
      frame_check_rx <= mis ? ~r : r;
      frame_clear <= clr;
      tick(1);
      frame_word_valid <= 1'b0;
      frame_clear <= 1'b0;
      tick(2);
      check("ferr", frame_error_flag, exp);
      check("init", init_status_n, !exp);
   endtask
   // ********************************************************************
   // Main sequence
   // ********************************************************************
   initial begin
      nrst = 1'b0;
      {start, user_clock_source, scan_clock_source, clk_mgr_locked, impedance_match,
       design_uses_match, done_pipeline, config_done_pin, live_reconfig_hold, in_configuration,
       readback_req, reconfig_req, frame_check_insert, frame_word_valid, frame_clear,
       port_access, monitor_safe_reconfig, partial_reconfig, bram_req, cfg_go, cfg_slow} = '0;
      {readback_lock_level, frame_check_calc, frame_check_rx, cfg_cnt} = '0;
      phase_cfg = '0;
      sequencer_clock_sel = css_pkg::CSS_CLK_CONFIG;
      internal_port_sel = css_pkg::CSS_PORT_AUTO;
      void'($urandom(32'h1E2B));
      tick(4);
      check("rst", {glob_q, init_status_n, phase_q}, 32'h21 << 3);
      for (int k = 0; k < 6; k++) begin
         c.done_sel = 4'(1 + $urandom % 6);
         c.io_rel_sel = 4'(1 + $urandom % 6);
         c.we_sel = 4'(1 + $urandom % 6);
         c.lock_sel = `CSS_SEL_NO_WAIT;
         c.imp_sel = `CSS_SEL_NO_WAIT;
         n = 1 + $urandom % 9;
         clk_mgr_locked <= 1'($urandom);
         bram_req <= 1'b1;
         restart(css_pkg::css_clk_sel_t'(k % 3), c);
         rises(n);
         p = exp_phase(n, 7);
         check("phase", phase_q, p);
         check("tri", glob_q.tristate, p < c.io_rel_sel[2:0]);
         check("we", glob_q.write_en, p >= c.we_sel[2:0]);
         check("bram", {bram_grant, glob_q.bram_en}, {2{p >= c.we_sel[2:0]}});
         check("done", config_done, p >= c.done_sel[2:0]);
      end
      c.lock_sel = 4'h3;
      clk_mgr_locked <= 1'b0;
      restart(css_pkg::CSS_CLK_CONFIG, c);
      rises(6);
      check("lock", phase_q, 3'h3);
      clk_mgr_locked <= 1'b1;
      rises(2);
      check("lock", phase_q, 3'h5);
      c.lock_sel = `CSS_SEL_NO_WAIT;
      imp_case(`CSS_SEL_AUTO, 1'b1, 5, 2);
      imp_case(`CSS_SEL_AUTO, 1'b0, 4, 7);
      imp_case(4'h0, 1'b0, 3, 0);
      c = {`CSS_DONE_DEF, `CSS_IO_REL_DEF, `CSS_WE_DEF, `CSS_SEL_NO_WAIT, `CSS_SEL_NO_WAIT};
      done_pipeline <= 1'b1;
      restart(css_pkg::CSS_CLK_CONFIG, c);
      cfg_cnt <= 4'hF;
      cfg_go <= 1'b1;
      tick(1);
      cfg_go <= 1'b0;
      tick(60);
      check("done", config_done, 1'b0);
      config_done_pin <= 1'b1;
      for (int i = 0; i < 40 && config_done !== 1'b1; i++) tick(1);
      check("done", {config_done, glob_q.done}, 2'h3);
      tick(10);
      check("cclk", config_clock, 1'b0);
      for (int i = 0; i < 3; i++) begin
         readback_lock_level <= 2'(i);
         internal_port_sel <= css_pkg::css_port_sel_t'(i);
         {readback_req, reconfig_req, port_access, partial_reconfig} <= 4'hF;
         {live_reconfig_hold, in_configuration} <= {i != 0, 1'b1};
         monitor_safe_reconfig <= (i == 1);
         tick(3);
         check("rdbk", readback_grant, i == 0);
         check("rcfg", reconfig_grant, i != 2);
         check("top", port_top_sel, i != 2);
         check("bot", port_bottom_sel, i == 2);
         check("mon", monitor_safe_mode, i == 1);
         check("hold", {glob_q.out_hold, glob_q.set_reset}, {2{i == 0}});
      end
      frame_op(1'b1, 1'b1, 1'b0, 1'b1);
      frame_op(1'b1, 1'b0, 1'b1, 1'b0);
      frame_op(1'b0, 1'b1, 1'b0, 1'b0);
      frame_op(1'b1, 1'b1, 1'b1, 1'b1);
      frame_op(1'b1, 1'b0, 1'b0, 1'b1);
      give_verdict();
   end
   // A hang counts as a mismatch and ends the run through the same verdict.
   initial begin
      tick(6000);
      err_total++;
      give_verdict();
   end
endmodule
`default_nettype wire
